//--- design/fpv_cell_array.sv
`timescale 1ns/1ps
module fpv_cell_array
   import fpv_pkg::*;
(
   input  wire logic                    clock,     // System clock
   input  wire logic                    reset_n,   // Async reset, array erased
   input  wire logic                    progEn,    // Commit one program pulse
   input  wire logic                    eraseEn,   // Commit one erase pulse
   input  wire logic [2:0]              pageIndex, // Target page
   input  wire logic [PAGE_BYTES*8-1:0] pageData,  // Zero bits get programmed
   input  wire logic [7:0]              readAddr,  // Longword index
   output logic      [31:0]             readData   // Longword, byte 0 low
);

   logic [7:0] cellMem [ARRAY_BYTES];

   // Programming only pulls bits from 1 to 0; erase restores 1
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < ARRAY_BYTES; k++) begin
            cellMem[k] <= 8'hFF;
         end
      end else begin
         for (int k = 0; k < PAGE_BYTES; k++) begin
            if (eraseEn) begin
               cellMem[{pageIndex, 7'(k)}] <= ERASED_BYTE;
            end else if (progEn) begin
               cellMem[{pageIndex, 7'(k)}] <= cellMem[{pageIndex, 7'(k)}] & pageData[k*8 +: 8];
            end
         end
      end
   end

   assign readData = {cellMem[{readAddr, 2'd3}], cellMem[{readAddr, 2'd2}],
                      cellMem[{readAddr, 2'd1}], cellMem[{readAddr, 2'd0}]};

endmodule

//--- design/fpv_flash_seq.sv
`timescale 1ns/1ps
// How it works
// - Four modes entered through setup, pulse and verify bits of mode control register.
// - Array reads return no data while program or erase setup or pulse bits are active.
// - Nothing is programmed or erased unless write enable input is high.
// - Pages are 128 consecutive byte writes treated as one unit.
// - Page address and data are latched for later program; the latched address also selects the page to erase.
// - Setup, wait, pulse bit; pulse lasts exactly while pulse bit is set.
// - Dummy FF write captures address; next read returns that word.
module fpv_flash_seq
   import fpv_pkg::*;
(
   input  wire logic        clock,                  // 20 MHz system clock
   input  wire logic        reset_n,                // Async reset
   input  wire logic        psel,                   // APB select
   input  wire logic        penable,                // APB access phase
   input  wire logic        pwrite,                 // APB direction
   input  wire logic [11:0] paddr,                  // APB byte address
   input  wire logic [31:0] pwdata,                 // APB write data
   input  wire logic [3:0]  pstrb,                  // APB byte strobes
   input  wire logic        flashWriteEnableInput,  // Write enable pin
   output logic      [31:0] prdata,                 // APB read data
   output logic             pready,                 // APB ready
   output logic             pslverr                 // APB error
);

   fpv_apb_req_s req;
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};

   // Pin synchroniser
   logic fweMeta;
   logic fweSync;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fweMeta <= 1'b0;
         fweSync <= 1'b0;
      end else begin
         fweMeta <= flashWriteEnableInput;
         fweSync <= fweMeta;
      end
   end

   // State
   fpv_mode_s   mode;
   fpv_mode_s   next_mode;
   fpv_phase_e  phase;
   fpv_phase_e  next_phase;
   fpv_width_e  pulseClass;
   fpv_width_e  next_pulseClass;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [7:0]  byteCount;
   logic [7:0]  next_byteCount;
   logic [9:0]  pageBase;
   logic [9:0]  next_pageBase;
   logic        alignErr;
   logic        next_alignErr;
   logic [9:0]  passCount;
   logic [9:0]  next_passCount;
   logic [15:0] pulseCycles;
   logic [15:0] next_pulseCycles;
   logic [15:0] lastPulse;
   logic [15:0] next_lastPulse;
   logic        prevProg;
   logic        prevErase;
   logic [7:0]  pvCycles;
   logic [7:0]  next_pvCycles;
   logic [7:0]  dummyCycles;
   logic [7:0]  next_dummyCycles;
   logic        dummySeen;
   logic        next_dummySeen;
   logic [7:0]  verifyAddr;
   logic [7:0]  next_verifyAddr;

   // Decode
   logic        access;
   logic        wrReg;
   logic        wrWin;
   logic        busy;
   logic        allowed;
   logic        pageFull;
   logic        applyProg;
   logic        applyErase;
   logic        progEn;
   logic        eraseEn;
   logic        loadEn;
   logic        verifyReady;
   logic [1:0]  lane;
   logic [7:0]  laneByte;
   logic [9:0]  byteAddr;
   logic [7:0]  readAddr;
   logic [31:0] arrayWord;
   logic [PAGE_BYTES*8-1:0] pageData;

   assign access      = psel && penable && pready;
   assign wrReg       = access && req.write && !req.addr[WINDOW_BIT];
   assign wrWin       = access && req.write && req.addr[WINDOW_BIT];
   assign busy        = mode.programSetup || mode.programPulse
                        || mode.eraseSetup || mode.erasePulse;
   assign allowed     = fweSync && mode.softwareWriteEnable;
   assign pageFull    = (byteCount == 8'(PAGE_BYTES));
   assign applyProg   = allowed && mode.programSetup && mode.programPulse
                        && pageFull;
   assign applyErase  = allowed && mode.eraseSetup && mode.erasePulse;
   assign progEn      = prevProg && !applyProg;
   assign eraseEn     = prevErase && !applyErase;
   assign lane        = req.strb[0] ? 2'd0 : req.strb[1] ? 2'd1 : req.strb[2] ? 2'd2 : 2'd3;
   assign laneByte    = req.wdata[{lane, 3'b000} +: 8];
   assign byteAddr    = {req.addr[9:2], lane};
   assign readAddr    = mode.programVerify ? verifyAddr : req.addr[9:2];
   assign verifyReady = mode.programVerify && dummySeen
                        && (pvCycles >= 8'(VERIFY_SETUP_CYC))
                        && (dummyCycles >= 8'(DUMMY_WRITE_CYC));

   // Byte writes must open on a page boundary and then run on consecutively
   always_comb begin
      loadEn = 1'b0;
      if (wrWin && allowed && !busy && !mode.programVerify && !pageFull) begin
         if (byteCount == 8'd0) begin
            loadEn = (byteAddr[6:0] == 7'd0);
         end else begin
            loadEn = (byteAddr == pageBase + 10'(byteCount));
         end
      end
   end

   fpv_page_latch uPageLatch (
      .clock     (clock),
      .reset_n   (reset_n),
      .clear     (progEn || !mode.softwareWriteEnable),
      .loadEn    (loadEn),
      .loadIndex (byteAddr[6:0]),
      .loadByte  (laneByte),
      .pageData  (pageData)
   );

   fpv_cell_array uCellArray (
      .clock     (clock),
      .reset_n   (reset_n),
      .progEn    (progEn),
      .eraseEn   (eraseEn),
      .pageIndex (pageBase[9:7]),
      .pageData  (pageData),
      .readAddr  (readAddr),
      .readData  (arrayWord)
   );

   // Mode bits and phase
   always_comb begin
      next_mode = mode;
      if (wrReg && (req.addr == REG_MODE_CTRL) && req.strb[0]) begin
         next_mode = fpv_mode_s'(req.wdata[6:0]);
      end
      if (!next_mode.softwareWriteEnable) begin
         next_mode = '0;
      end
      next_phase = PH_IDLE;
      if (applyErase) begin
         next_phase = PH_ERASE;
      end else if (applyProg) begin
         next_phase = PH_PULSE;
      end else if (mode.programSetup) begin
         next_phase = PH_SETUP;
      end else if (mode.programVerify) begin
         next_phase = PH_VERIFY;
      end else if (byteCount != 8'd0) begin
         next_phase = PH_LOAD;
      end
   end

   // Page capture and pass counting
   always_comb begin
      next_byteCount = byteCount;
      next_pageBase  = pageBase;
      next_alignErr  = alignErr;
      next_passCount = passCount;
      if (wrWin && allowed && !busy && !mode.programVerify) begin
         next_alignErr = !loadEn;
      end
      if (loadEn) begin
         next_byteCount = byteCount + 8'd1;
         if (byteCount == 8'd0) begin
            next_pageBase = byteAddr;
            if (byteAddr != pageBase) begin
               next_passCount = 10'd0;
            end
         end
      end
      if (progEn || !mode.softwareWriteEnable) begin
         next_byteCount = 8'd0;
      end
      if (progEn && (passCount != MAX_PASSES)) begin
         next_passCount = passCount + 10'd1;
      end
   end

   // Pulse width measurement
   always_comb begin
      next_pulseCycles = applyProg ? pulseCycles + 16'd1 : 16'd0;
      if (pulseCycles == 16'hFFFF) begin
         next_pulseCycles = pulseCycles;
      end
      next_lastPulse  = lastPulse;
      next_pulseClass = pulseClass;
      if (progEn) begin
         next_lastPulse = pulseCycles;
         if (pulseCycles >= 16'(LONG_PULSE_CYC)) begin
            next_pulseClass = PW_LONG;
         end else if (pulseCycles >= 16'(SHORT_PULSE_CYC)) begin
            next_pulseClass = PW_SHORT;
         end else if (pulseCycles >= 16'(ADD_PULSE_CYC)) begin
            next_pulseClass = PW_ADD;
         end else begin
            next_pulseClass = PW_NONE;
         end
      end
   end

   // Verify timing and dummy write capture
   always_comb begin
      next_pvCycles    = 8'd0;
      next_dummyCycles = dummyCycles;
      next_dummySeen   = dummySeen && mode.programVerify;
      next_verifyAddr  = verifyAddr;
      if (mode.programVerify) begin
         next_pvCycles = (pvCycles == 8'hFF) ? pvCycles : pvCycles + 8'd1;
         if (dummyCycles != 8'hFF) begin
            next_dummyCycles = dummyCycles + 8'd1;
         end
      end
      if (wrWin && mode.programVerify) begin
         next_verifyAddr  = req.addr[9:2];
         next_dummyCycles = 8'd0;
         next_dummySeen   = 1'b1;
      end
   end

   // APB answer, prepared in the setup cycle
   always_comb begin
      next_pready  = 1'b0;
      next_prdata  = RESET_WORD;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pready = 1'b1;
         if (req.addr[WINDOW_BIT]) begin
            if (busy) begin
               next_pslverr = 1'b1;
            end else if (!req.write) begin
               next_prdata = arrayWord;
            end
         end else begin
            case (req.addr)
               REG_MODE_CTRL: begin
                  next_prdata[6:0]          = mode;
                  next_prdata[MODE_FWE_BIT] = fweSync;
               end
               REG_STATUS: begin
                  next_prdata[ST_PHASE_LSB +: 3]  = phase;
                  next_prdata[ST_FULL_BIT]        = pageFull;
                  next_prdata[ST_ALIGN_BIT]       = alignErr;
                  next_prdata[ST_VRDY_BIT]        = verifyReady;
                  next_prdata[ST_COUNT_LSB +: 8]  = byteCount;
                  next_prdata[ST_PASS_LSB +: 10]  = passCount;
               end
               REG_PULSE: begin
                  next_prdata[15:0]              = lastPulse;
                  next_prdata[PULSE_CLS_LSB +: 2] = pulseClass;
               end
               REG_PAGE_BASE: begin
                  next_prdata[9:0] = pageBase;
               end
               default: begin
                  next_pslverr = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mode        <= '0;
         phase       <= PH_IDLE;
         pulseClass  <= PW_NONE;
         prdata      <= RESET_WORD;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         byteCount   <= 8'd0;
         pageBase    <= 10'd0;
         alignErr    <= 1'b0;
         passCount   <= 10'd0;
         pulseCycles <= 16'd0;
         lastPulse   <= 16'd0;
         prevProg    <= 1'b0;
         prevErase   <= 1'b0;
         pvCycles    <= 8'd0;
         dummyCycles <= 8'd0;
         dummySeen   <= 1'b0;
         verifyAddr  <= 8'd0;
      end else begin
         mode        <= next_mode;
         phase       <= next_phase;
         pulseClass  <= next_pulseClass;
         prdata      <= next_prdata;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
         byteCount   <= next_byteCount;
         pageBase    <= next_pageBase;
         alignErr    <= next_alignErr;
         passCount   <= next_passCount;
         pulseCycles <= next_pulseCycles;
         lastPulse   <= next_lastPulse;
         prevProg    <= applyProg;
         prevErase   <= applyErase;
         pvCycles    <= next_pvCycles;
         dummyCycles <= next_dummyCycles;
         dummySeen   <= next_dummySeen;
         verifyAddr  <= next_verifyAddr;
      end
   end

endmodule

//--- design/fpv_page_latch.sv
`timescale 1ns/1ps
module fpv_page_latch
   import fpv_pkg::*;
(
   input  wire logic                      clock,     // System clock
   input  wire logic                      reset_n,   // Async reset
   input  wire logic                      clear,     // Refill page with erased bytes
   input  wire logic                      loadEn,    // Capture one byte
   input  wire logic [6:0]                loadIndex, // Byte index in page
   input  wire logic [7:0]                loadByte,  // Byte captured
   output logic      [PAGE_BYTES*8-1:0]   pageData   // Latched page, byte 0 low
);

   logic [7:0] latchMem [PAGE_BYTES];
   logic [7:0] next_latchMem [PAGE_BYTES];

   genvar i;
   generate
      for (i = 0; i < PAGE_BYTES; i++) begin : gEntry
         always_comb begin
            next_latchMem[i] = latchMem[i];
            if (clear) begin
               next_latchMem[i] = ERASED_BYTE;
            end else if (loadEn && (loadIndex == 7'(i))) begin
               next_latchMem[i] = loadByte;
            end
         end
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               latchMem[i] <= 8'hFF;
            end else begin
               latchMem[i] <= next_latchMem[i];
            end
         end
         assign pageData[i*8 +: 8] = latchMem[i];
      end
   endgenerate

endmodule

//--- design/fpv_pkg.sv
package fpv_pkg;

   // Register byte offsets on the APB window
   localparam logic [11:0] REG_MODE_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS    = 12'h004;
   localparam logic [11:0] REG_PULSE     = 12'h008;
   localparam logic [11:0] REG_PAGE_BASE = 12'h00C;
   localparam int          WINDOW_BIT    = 10;

   // Array geometry
   localparam int          PAGE_BYTES    = 128;
   localparam int          ARRAY_BYTES   = 1024;
   localparam int          PAGE_COUNT    = ARRAY_BYTES / PAGE_BYTES;
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
   localparam logic [9:0]  MAX_PASSES    = 10'd1000;

   // Field positions in the status, pulse and mode control registers
   localparam int          ST_PHASE_LSB  = 0;
   localparam int          ST_FULL_BIT   = 3;
   localparam int          ST_ALIGN_BIT  = 4;
   localparam int          ST_VRDY_BIT   = 5;
   localparam int          ST_COUNT_LSB  = 8;
   localparam int          ST_PASS_LSB   = 16;
   localparam int          PULSE_CLS_LSB = 16;
   localparam int          MODE_FWE_BIT  = 7;

   // Timing
   localparam int unsigned CLK_PERIOD_NS        = 50;
   localparam int unsigned ADD_PULSE_MIN_NS     = 8000;
   localparam int unsigned SHORT_PULSE_MIN_NS   = 28000;
   localparam int unsigned LONG_PULSE_MIN_NS    = 198000;
   localparam int unsigned VERIFY_SETUP_WAIT_NS = 4000;
   localparam int unsigned DUMMY_WRITE_WAIT_NS  = 2000;
   localparam int unsigned ADD_PULSE_CYC    = (ADD_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SHORT_PULSE_CYC  = (SHORT_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LONG_PULSE_CYC   = (LONG_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned VERIFY_SETUP_CYC = (VERIFY_SETUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DUMMY_WRITE_CYC  = (DUMMY_WRITE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      PH_IDLE   = 3'b000,
      PH_LOAD   = 3'b001,
      PH_SETUP  = 3'b011,
      PH_PULSE  = 3'b010,
      PH_VERIFY = 3'b110,
      PH_ERASE  = 3'b111
   } fpv_phase_e;

   typedef enum logic [1:0] {
      PW_NONE  = 2'b00,
      PW_ADD   = 2'b01,
      PW_SHORT = 2'b10,
      PW_LONG  = 2'b11
   } fpv_width_e;

   // Mode control bits, bit 6 first
   typedef struct packed {
      logic eraseVerify;
      logic erasePulse;
      logic eraseSetup;
      logic programVerify;
      logic programPulse;
      logic programSetup;
      logic softwareWriteEnable;
   } fpv_mode_s;

   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic [31:0] wdata;
      logic [3:0]  strb;
   } fpv_apb_req_s;

endpackage

//--- tb/fpv_cpu_model.sv
`timescale 1ns/1ps
module fpv_cpu_model
   import fpv_pkg::*;
(
   input  wire logic        clock,   // System clock
   output logic             psel,    // Select
   output logic             penable, // Access
   output logic             pwrite,  // Direction
   output logic      [11:0] paddr,   // Address
   output logic      [31:0] pwdata,  // Write data
   output logic      [3:0]  pstrb,   // Strobes
   input  wire logic [31:0] prdata,  // Read data
   input  wire logic        pready,  // Ready
   input  wire logic        pslverr  // Error
);
   logic [31:0] rdata;
   logic        rerr;
   logic [31:0] pulseData;
   logic        pulseErr;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      // Byte writes go in the lane that the address names
      pwdata <= d << {a[1:0], 3'b000};
      pstrb <= w ? 4'(1 << a[1:0]) : 4'h0;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Full page, unused bytes padded erased
   task automatic load_page(input logic [11:0] base, input int used, input logic [7:0] seed);
      for (int i = 0; i < PAGE_BYTES; i++) begin
         xfer(1'b1, base + 12'(i),
              {24'h0, i < used ? 8'(i) ^ seed : ERASED_BYTE});
      end
   endtask
   // Setup, timed pulse, then timed release
   task automatic program_pass(input int pw);
      xfer(1'b1, REG_MODE_CTRL, 32'h0000_0003);
      wait_cyc(1000);
      xfer(1'b1, REG_MODE_CTRL, 32'h0000_0007);
      xfer(1'b0, 12'h400, 32'h0000_0000);
      pulseData = rdata;
      pulseErr = rerr;
      wait_cyc(pw);
      xfer(1'b1, REG_MODE_CTRL, 32'h0000_0003);
      wait_cyc(100);
      xfer(1'b1, REG_MODE_CTRL, 32'h0000_0001);
      wait_cyc(100);
   endtask
   task automatic verify_word(input logic [11:0] a);
      xfer(1'b1, a, 32'h0000_00FF);
      wait_cyc(42);
      xfer(1'b0, 12'h400, 32'h0000_0000);
   endtask
endmodule

//--- tb/fpv_flash_seq_assertions.sv
`timescale 1ns/1ps
module fpv_flash_seq_assertions
   import fpv_pkg::*;
(
   input wire logic        clock,                 // Clock
   input wire logic        reset_n,               // Reset
   input wire logic        psel,                  // Select
   input wire logic        penable,               // Access
   input wire logic        pwrite,                // Direction
   input wire logic [11:0] paddr,                 // Address
   input wire logic [31:0] pwdata,                // Write data
   input wire logic [3:0]  pstrb,                 // Strobes
   input wire logic        flashWriteEnableInput, // Pin
   input wire logic [31:0] prdata,                // Read data
   input wire logic        pready,                // Ready
   input wire logic        pslverr                // Error
);
   logic [2:0] lowCnt;
   logic [2:0] next_lowCnt;
   // Cycles the pin has been low, saturating
   always_comb begin
      next_lowCnt = lowCnt;
      if (flashWriteEnableInput) begin
         next_lowCnt = 3'd0;
      end else if (lowCnt != 3'd7) begin
         next_lowCnt = lowCnt + 3'd1;
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt <= 3'd0;
      end else begin
         lowCnt <= next_lowCnt;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_has_cause: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused access returned data");
   a_unmapped_err: assert property (pready && !paddr[11] && !paddr[WINDOW_BIT]
      && paddr[9:4] != 6'h00 |-> pslverr)
      else $error("unmapped offset accepted");
   a_mapped_ok: assert property (pready && paddr[11:4] == 8'h00
      && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped register refused");
   a_pin_mirror: assert property (pready && !pwrite && paddr == REG_MODE_CTRL
      && lowCnt == 3'd7 |-> !prdata[MODE_FWE_BIT])
      else $error("pin low not seen in mode bit");
endmodule

bind fpv_flash_seq fpv_flash_seq_assertions u_chk (
   .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .flashWriteEnableInput(flashWriteEnableInput), .prdata(prdata), .pready(pready),
   .pslverr(pslverr)
);

//--- tb/tb_fpv_flash_seq.sv
`timescale 1ns/1ps
module tb_fpv_flash_seq;
   import fpv_pkg::*;
   logic        clock;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        flashWriteEnableInput;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          failures;
   int          samples_checked;
   int          cycles;
   int          pw [3] = '{600, 4000, 200};
   logic [1:0]  cls [3] = '{PW_SHORT, PW_LONG, PW_ADD};
   fpv_flash_seq dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .flashWriteEnableInput(flashWriteEnableInput), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   fpv_cpu_model cpu (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial clock = 1'b0;
   always #25 clock = ~clock;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         print_verdict;
      end
   end
   initial begin
      reset_n = 1'b0;
      flashWriteEnableInput = 1'b1;
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      // Pin level needs two edges through its synchroniser
      cpu.wait_cyc(2);
      cpu.xfer(1'b0, REG_MODE_CTRL, 32'h0000_0000);
      check(cpu.rdata, 32'h0000_0080);
      cpu.xfer(1'b0, REG_STATUS, 32'h0000_0000);
      check(cpu.rdata, 32'h0000_0000);
      cpu.xfer(1'b0, 12'h010, 32'h0000_0000);
      check({31'h0, cpu.rerr}, 32'h0000_0001);
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0001);
      cpu.wait_cyc(200);
      cpu.xfer(1'b1, 12'h481, 32'h0000_0000);
      cpu.xfer(1'b0, REG_STATUS, 32'h0000_0000);
      check({31'h0, cpu.rdata[ST_ALIGN_BIT]}, 32'h0000_0001);
      for (int k = 0; k < 3; k++) begin
         cpu.load_page(12'h480, k == 0 ? 64 : 0, 8'h00);
         cpu.xfer(1'b0, REG_STATUS, 32'h0000_0000);
         check({16'h0, cpu.rdata[15:8], 7'h0, cpu.rdata[ST_FULL_BIT]}, 32'h0000_8001);
         cpu.xfer(1'b0, REG_PAGE_BASE, 32'h0000_0000);
         check(cpu.rdata, 32'h0000_0080);
         cpu.program_pass(pw[k]);
         check({cpu.pulseData[30:0], cpu.pulseErr}, 32'h0000_0001);
         cpu.xfer(1'b0, REG_PULSE, 32'h0000_0000);
         check({30'h0, cpu.rdata[17:16]}, {30'h0, cls[k]});
         cpu.xfer(1'b0, REG_STATUS, 32'h0000_0000);
         check({22'h0, cpu.rdata[25:16]}, 32'(k + 1));
      end
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0009);
      cpu.wait_cyc(82);
      cpu.verify_word(12'h480);
      check(cpu.rdata, 32'h0302_0100);
      cpu.xfer(1'b0, REG_STATUS, 32'h0000_0000);
      check({31'h0, cpu.rdata[ST_VRDY_BIT]}, 32'h0000_0001);
      cpu.verify_word(12'h4C0);
      check(cpu.rdata, 32'hFFFF_FFFF);
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0001);
      cpu.wait_cyc(40);
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0000);
      cpu.wait_cyc(2000);
      flashWriteEnableInput <= 1'b0;
      cpu.wait_cyc(10);
      cpu.xfer(1'b0, REG_MODE_CTRL, 32'h0000_0000);
      check(cpu.rdata, 32'h0000_0000);
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0001);
      cpu.wait_cyc(200);
      cpu.load_page(12'h500, 128, 8'h55);
      cpu.program_pass(600);
      cpu.xfer(1'b0, 12'h500, 32'h0000_0000);
      check(cpu.rdata, 32'hFFFF_FFFF);
      // Erase the page at 0x480 programmed in the loop
      flashWriteEnableInput <= 1'b1;
      cpu.wait_cyc(10);
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0031);
      cpu.wait_cyc(200);
      cpu.xfer(1'b1, REG_MODE_CTRL, 32'h0000_0001);
      cpu.xfer(1'b0, 12'h480, 32'h0000_0000);
      check(cpu.rdata, 32'hFFFF_FFFF);
      print_verdict;
   end
endmodule
